// *** rtl/rtu_frame_crc_and_exception_reply.sv ***
// Frame check generation and checking plus error reply building.
// Assumes bytes arrive as data bits only and frame boundaries are marked
// by an outside timing block; the request decoder supplies fault causes.
//
// Functional notes
// - Transmitter appends 16-bit check to frame.
// - Receiver recomputes check; mismatch is an error.
// - Check register starts each frame all ones.
// - Only eight data bits enter the check.
// - Each byte is XORed into the register.
// - Shift right, zero in, fold if one out.
// - Exactly eight shift steps per byte.
// - Final register value is the frame check.
// - Good reply echoes the function code.
// - Failed reply sets function code top bit.
// - Error reply carries one cause byte.
// - Cause 01H for unsupported function.
// - Cause 02H for illegal address.
// - Cause 03H for out-of-range value.
// - Cause 11H for check field mismatch.
module rtu_frame_crc_and_exception_reply (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// Receive side: data bytes of a request, check field included.
	input  wire logic        i_rx_sof,
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_data,
	input  wire logic        i_rx_eof,
	output logic             o_rx_ready,
	output logic             o_rx_done,
	output logic             o_rx_crc_ok,
	output logic             o_rx_crc_err,
	// Request outcome from the decoder.
	input  wire logic        i_rep_start,
	input  wire logic [7:0]  i_rep_func,
	input  wire logic        i_rep_bad_func,
	input  wire logic        i_rep_bad_addr,
	input  wire logic        i_rep_bad_value,
	output logic             o_exc_valid,
	output logic [7:0]  o_exc_func,
	output logic [7:0]  o_exc_cause,
	// Transmit side: body bytes in, body plus check out.
	input  wire logic        i_tx_sof,
	input  wire logic        i_tx_valid,
	input  wire logic [7:0]  i_tx_data,
	input  wire logic        i_tx_eof,
	output logic             o_tx_ready,
	output logic             o_tx_valid,
	output logic [7:0]  o_tx_data,
	output logic             o_tx_last
);
	typedef enum logic [3:0] {
		TX_BODY = 4'h1,
		TX_WAIT = 4'h2,
		TX_CLO  = 4'h4,
		TX_CHI  = 4'h8
	} tx_state_t;

	tx_state_t   tx_q;
	logic        rx_rdy, tx_rdy;
	logic [15:0] rx_crc, tx_crc;
	logic [15:0] rx_last2_q;
	logic        rx_seen_q, rx_check_q, rx_fail_q;
	logic [15:0] tx_hold_q;
	// A clean frame folded together with its own field leaves this residue.
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;

	// Receive engine folds every byte including the trailing check field.
	// It takes a byte on the same edge as the field capture, never earlier.
	crc_byte_engine u_rx_crc (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (i_rx_sof),
		.i_valid   (i_rx_valid && o_rx_ready),
		.i_data    (i_rx_data),
		.o_ready   (rx_rdy),
		.o_crc     (rx_crc)
	);

	// Transmit engine folds body bytes only.
	crc_byte_engine u_tx_crc (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (i_tx_sof),
		.i_valid   (i_tx_valid && o_tx_ready && tx_q == TX_BODY),
		.i_data    (i_tx_data),
		.o_ready   (tx_rdy),
		.o_crc     (tx_crc)
	);

	// Receive ready flag, registered; it falls the cycle after a byte is taken.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rx_ready <= 1'b0;
		end else begin
			o_rx_ready <= rx_rdy && !(i_rx_valid && o_rx_ready);
		end
	end

	// Keep the last two received bytes: they are the check field.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_rx_sof) begin
			rx_last2_q <= 16'h0000;
		end else if (i_rx_valid && o_rx_ready) begin
			rx_last2_q <= {i_rx_data, rx_last2_q[15:8]};
		end
	end

	// End of frame waits for the last byte to finish folding.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_rx_sof) begin
			rx_seen_q  <= 1'b0;
			rx_check_q <= 1'b0;
		end else begin
			if (i_rx_eof) begin
				rx_seen_q <= 1'b1;
			end
			rx_check_q <= 1'b0;
			if ((rx_seen_q || i_rx_eof) && rx_rdy && !rx_check_q) begin
				rx_seen_q  <= 1'b0;
				rx_check_q <= 1'b1;
			end
		end
	end

	// Compare the value folded over body and field with the zero residue.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rx_done    <= 1'b0;
			o_rx_crc_ok  <= 1'b0;
			o_rx_crc_err <= 1'b0;
			rx_fail_q    <= 1'b0;
		end else begin
			o_rx_done    <= rx_check_q;
			o_rx_crc_ok  <= 1'b0;
			o_rx_crc_err <= 1'b0;
			if (rx_check_q) begin
				// Folding the field too leaves zero on a clean frame.
				o_rx_crc_ok  <= (rx_crc == CRC_RESIDUE);
				o_rx_crc_err <= (rx_crc != CRC_RESIDUE);
				rx_fail_q    <= (rx_crc != CRC_RESIDUE);
			end else if (i_rx_sof) begin
				rx_fail_q <= 1'b0;
			end
		end
	end

	// Build the reply header: echo on success, flagged code plus cause.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_exc_valid <= 1'b0;
			o_exc_func  <= 8'h00;
			o_exc_cause <= rtu_crc_pkg::CAUSE_NONE;
		end else begin
			o_exc_valid <= 1'b0;
			if (i_rep_start) begin
				o_exc_valid <= 1'b1;
				o_exc_func  <= i_rep_func | rtu_crc_pkg::FUNC_ERR_BIT;
				if (rx_fail_q) begin
					o_exc_cause <= rtu_crc_pkg::CAUSE_CHECK;
				end else if (i_rep_bad_func) begin
					o_exc_cause <= rtu_crc_pkg::CAUSE_FUNC;
				end else if (i_rep_bad_addr) begin
					o_exc_cause <= rtu_crc_pkg::CAUSE_ADDR;
				end else if (i_rep_bad_value) begin
					o_exc_cause <= rtu_crc_pkg::CAUSE_VALUE;
				end else begin
					o_exc_func  <= i_rep_func;
					o_exc_cause <= rtu_crc_pkg::CAUSE_NONE;
					o_exc_valid <= 1'b0;
				end
			end
		end
	end

	// Transmit sequencer: pass body, wait, then append check bytes.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_tx_sof) begin
			tx_q       <= TX_BODY;
			o_tx_valid <= 1'b0;
			o_tx_data  <= 8'h00;
			o_tx_last  <= 1'b0;
			o_tx_ready <= 1'b0;
			tx_hold_q  <= 16'h0000;
		end else begin
			o_tx_valid <= 1'b0;
			o_tx_last  <= 1'b0;
			unique case (tx_q)
				TX_BODY: begin
					o_tx_ready <= tx_rdy && !(i_tx_valid && o_tx_ready)
						&& !i_tx_eof;
					if (i_tx_valid && o_tx_ready) begin
						o_tx_valid <= 1'b1;
						o_tx_data  <= i_tx_data;
					end
					if (i_tx_eof) begin
						o_tx_ready <= 1'b0;
						tx_q       <= TX_WAIT;
					end
				end
				TX_WAIT: begin
					// The value is held so the two check bytes stay fixed.
					if (tx_rdy) begin
						tx_hold_q <= tx_crc;
						tx_q      <= TX_CLO;
					end
				end
				TX_CLO: begin
					o_tx_valid <= 1'b1;
					o_tx_data  <= tx_hold_q[7:0];
					tx_q       <= TX_CHI;
				end
				TX_CHI: begin
					o_tx_valid <= 1'b1;
					o_tx_data  <= tx_hold_q[15:8];
					o_tx_last  <= 1'b1;
					tx_q       <= TX_BODY;
				end
			endcase
		end
	end

	// Assertions: transmit engine, body pass-through and appended field.
	a_preset_on_start: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		i_tx_sof |=> tx_crc == rtu_crc_pkg::CRC_PRESET)
		else $error("check register not preset at frame start");
	a_eight_steps: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_tx_valid && o_tx_ready && tx_rdy && tx_q == TX_BODY && !i_tx_sof)
		|=> !tx_rdy [*8] ##1 tx_rdy)
		else $error("byte did not take eight steps");
	a_tx_echo: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_tx_valid && o_tx_ready && tx_q == TX_BODY && !i_tx_sof)
		|=> o_tx_valid && o_tx_data == $past(i_tx_data))
		else $error("body byte not passed through");
	a_tx_hold: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(tx_q == TX_WAIT && tx_rdy && !i_tx_sof)
		|=> tx_hold_q == $past(tx_crc))
		else $error("final register value not kept");
	a_low_then_high: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(tx_q == TX_CLO && !i_tx_sof) |=> o_tx_valid && !o_tx_last
		&& o_tx_data == tx_hold_q[7:0] ##1 o_tx_last)
		else $error("check bytes out of order");
	a_high_last: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(tx_q == TX_CHI && !i_tx_sof) |=> o_tx_valid && o_tx_last
		&& o_tx_data == tx_hold_q[15:8])
		else $error("check high byte missing");
	a_last_valid: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		o_tx_last |-> o_tx_valid)
		else $error("final flag without a byte");
	// Assertions: receive path and verdict.
	a_rx_preset: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		i_rx_sof |=> rx_crc == rtu_crc_pkg::CRC_PRESET)
		else $error("receive register not preset at frame start");
	a_rx_steps: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rx_valid && o_rx_ready && rx_rdy && !i_rx_sof)
		|=> !rx_rdy [*8] ##1 rx_rdy)
		else $error("received byte did not take eight steps");
	a_rx_busy: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rx_valid && o_rx_ready) |=> !o_rx_ready)
		else $error("receive ready stayed high after a byte");
	a_rx_verdict: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		rx_check_q |=> (o_rx_crc_err == ($past(rx_crc) != CRC_RESIDUE))
		&& o_rx_done)
		else $error("receive verdict wrong");
	a_rx_pulses: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(o_rx_crc_ok || o_rx_crc_err)
		|-> o_rx_done && (o_rx_crc_ok != o_rx_crc_err))
		else $error("verdict flags inconsistent");
	// Assertions: reply header.
	a_err_top_bit: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		o_exc_valid |-> o_exc_func[7]
		&& o_exc_cause != rtu_crc_pkg::CAUSE_NONE)
		else $error("error reply lacks flag or cause");
	a_exc_header: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rep_start && (rx_fail_q || i_rep_bad_func || i_rep_bad_addr
		|| i_rep_bad_value)) |=> o_exc_valid
		&& o_exc_func == ($past(i_rep_func) | rtu_crc_pkg::FUNC_ERR_BIT))
		else $error("error reply header not built");
	a_cause_check: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rep_start && rx_fail_q)
		|=> o_exc_cause == rtu_crc_pkg::CAUSE_CHECK)
		else $error("check failure cause wrong");
	a_cause_func: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rep_start && !rx_fail_q && i_rep_bad_func)
		|=> o_exc_cause == rtu_crc_pkg::CAUSE_FUNC && o_exc_valid)
		else $error("function cause wrong");
	a_cause_addr: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rep_start && !rx_fail_q && !i_rep_bad_func && i_rep_bad_addr)
		|=> o_exc_cause == rtu_crc_pkg::CAUSE_ADDR)
		else $error("address cause wrong");
	a_cause_value: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rep_start && !rx_fail_q && !i_rep_bad_func && !i_rep_bad_addr
		&& i_rep_bad_value) |=> o_exc_cause == rtu_crc_pkg::CAUSE_VALUE)
		else $error("value cause wrong");
	a_good_echo: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(i_rep_start && !rx_fail_q && !i_rep_bad_func && !i_rep_bad_addr
		&& !i_rep_bad_value) |=> !o_exc_valid
		&& o_exc_func == $past(i_rep_func))
		else $error("good reply not echoed");
	// Main scenarios.
	c_tx_frame: cover property (@(posedge i_clk) o_tx_last);
	c_rx_ok: cover property (@(posedge i_clk) o_rx_crc_ok);
	c_rx_err: cover property (@(posedge i_clk) o_rx_crc_err);
	c_exc: cover property (@(posedge i_clk) o_exc_valid);
	c_good_echo: cover property (@(posedge i_clk) i_rep_start
		&& !rx_fail_q && !i_rep_bad_func && !i_rep_bad_addr
		&& !i_rep_bad_value);
endmodule // rtu_frame_crc_and_exception_reply

// *** rtl/rtu_crc_pkg.sv ***
// Constants shared by the frame check and error reply logic.
// Assumes a single 10 MHz system clock with synchronous active-high reset.
package rtu_crc_pkg;
	localparam logic [15:0] CRC_PRESET   = 16'hffff;
	localparam logic [15:0] CRC_POLY_REV = 16'ha001;
	localparam logic [3:0]  BIT_STEPS    = 4'h8;
	localparam logic [7:0]  FUNC_ERR_BIT = 8'h80;
	localparam logic [7:0]  CAUSE_FUNC   = 8'h01;
	localparam logic [7:0]  CAUSE_ADDR   = 8'h02;
	localparam logic [7:0]  CAUSE_VALUE  = 8'h03;
	localparam logic [7:0]  CAUSE_CHECK  = 8'h11;
	localparam logic [7:0]  CAUSE_NONE   = 8'h00;
endpackage

// *** rtl/crc_byte_engine.sv ***
// Bit-serial check engine: one byte is folded in over nine clock cycles, a load then eight shifts.
// Assumes the caller only offers a byte while o_ready is high.
module crc_byte_engine (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_start,
	input  wire logic        i_valid,
	input  wire logic [7:0]  i_data,
	output logic             o_ready,
	output logic [15:0]      o_crc
);
	logic [15:0] crc_q;
	logic [3:0]  cnt_q;
	logic [15:0] shifted;

	// One shift step with the conditional fold of the reversed polynomial.
	always_comb begin
		shifted = {1'b0, crc_q[15:1]};
		if (crc_q[0]) begin
			shifted = shifted ^ rtu_crc_pkg::CRC_POLY_REV;
		end
	end

	// Register update: preset, byte load, then eight shift steps.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_start) begin
			crc_q <= rtu_crc_pkg::CRC_PRESET;
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'h0) begin
			crc_q <= shifted;
			cnt_q <= cnt_q - 4'h1;
		end else if (i_valid) begin
			crc_q <= crc_q ^ {8'h00, i_data};
			cnt_q <= rtu_crc_pkg::BIT_STEPS;
		end
	end

	assign o_ready = (cnt_q == 4'h0) && !i_start;
	assign o_crc   = crc_q;
endmodule // crc_byte_engine

// *** bench/rtu_host_model.sv ***
// Master-side model: sends request frames with their check field appended
// and collects every byte the block transmits.
// Assumes one clock shared with the block and inputs sampled on rising edges.
module rtu_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_ready,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_last,
	output logic            o_sof,
	output logic            o_valid,
	output logic [7:0]      o_data,
	output logic            o_eof
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got_q[$];
	int         last_idx;

	// Reference check over data bytes only, one shift step per bit.
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = rtu_crc_pkg::CRC_PRESET;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ rtu_crc_pkg::CRC_POLY_REV) : (c >> 1);
		end
		return c;
	endfunction

	// Sends one frame; a corrupt frame has one bit of its check flipped.
	task automatic send_frame(input logic [7:0] body[$], input logic bad);
		logic [7:0]  f[$];
		logic [15:0] c;
		f = body;
		c = crc16(body);
		f.push_back(c[7:0] ^ {7'h00, bad});
		f.push_back(c[15:8]);
		@(posedge i_clk);
		#10 o_sof = 1'b1;
		@(posedge i_clk);
		#10 o_sof = 1'b0;
		foreach (f[i]) begin
			@(posedge i_clk);
			#10 o_valid = 1'b1;
			o_data = f[i];
			for (int n = 0; n < 20; n++) begin
				@(posedge i_clk);
				if (i_ready === 1'b1) break;
			end
			#10 o_valid = 1'b0;
			o_data = ~o_data; // Released line no longer shows the byte.
		end
		o_eof = 1'b1;
		@(posedge i_clk);
		#10 o_eof = 1'b0;
	endtask

	// Idle levels at time zero.
	initial begin
		o_sof = 1'b0;
		o_valid = 1'b0;
		o_data = 8'h00;
		o_eof = 1'b0;
		last_idx = -1;
	end

	// Collects transmitted bytes and notes where the final one fell.
	always @(posedge i_clk) begin
		if (i_tx_valid === 1'b1) begin
			if (i_tx_last === 1'b1) last_idx = got_q.size();
			got_q.push_back(i_tx_data);
		end
	end
endmodule // rtu_host_model

// *** bench/testbench.sv ***
// Self-checking bench for frame check and error reply logic.
// Assumes the host model drives the receive side and captures transmit.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk, i_sys_rst, rx_sof, rx_valid, rx_eof, o_rx_ready, o_rx_done;
	logic o_rx_crc_ok, o_rx_crc_err, rep_start, bad_f, bad_a, bad_v;
	logic o_exc_valid, tx_sof, tx_valid, tx_eof, o_tx_ready, o_tx_valid;
	logic o_tx_last, done_seen, ok_seen, err_seen;
	logic [7:0] rx_data, rep_func, o_exc_func, o_exc_cause, tx_data, o_tx_data;
	int errors, cmp_count, cycles;

	rtu_frame_crc_and_exception_reply dut_u (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_rx_sof(rx_sof), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .i_rx_eof(rx_eof), .o_rx_ready(o_rx_ready),
		.o_rx_done(o_rx_done), .o_rx_crc_ok(o_rx_crc_ok),
		.o_rx_crc_err(o_rx_crc_err), .i_rep_start(rep_start),
		.i_rep_func(rep_func), .i_rep_bad_func(bad_f), .i_rep_bad_addr(bad_a),
		.i_rep_bad_value(bad_v), .o_exc_valid(o_exc_valid),
		.o_exc_func(o_exc_func), .o_exc_cause(o_exc_cause), .i_tx_sof(tx_sof),
		.i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_eof(tx_eof),
		.o_tx_ready(o_tx_ready), .o_tx_valid(o_tx_valid),
		.o_tx_data(o_tx_data), .o_tx_last(o_tx_last));
	rtu_host_model host_u (.i_clk(i_clk), .i_ready(o_rx_ready),
		.i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_last(o_tx_last),
		.o_sof(rx_sof), .o_valid(rx_valid), .o_data(rx_data), .o_eof(rx_eof));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask

	task automatic wrap_up;
		$display("errors=%0d cmp_count=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Sends a frame and judges the single verdict pulse that follows.
	task automatic rx_case(input logic [7:0] body[$], input logic bad);
		done_seen = 1'b0;
		host_u.send_frame(body, bad);
		repeat (14) @(posedge i_clk);
		#10 check({13'h0, done_seen, ok_seen, err_seen},
			{13'h0, 1'b1, !bad, bad});
	endtask

	// Presents one decoder outcome and judges the reply header.
	task automatic rep_case(input logic [7:0] fn, input logic [2:0] why,
		input logic v, input logic [7:0] ef, input logic [7:0] ec);
		@(posedge i_clk);
		#10 rep_start = 1'b1;
		rep_func = fn;
		{bad_f, bad_a, bad_v} = why;
		@(posedge i_clk);
		#10 rep_start = 1'b0;
		check({15'h0, o_exc_valid}, {15'h0, v});
		check({o_exc_func, o_exc_cause}, {ef, ec});
	endtask

	// Sends a reply body and judges echo plus appended check bytes.
	task automatic tx_case(input logic [7:0] body[$], input logic [15:0] exp);
		int n;
		host_u.got_q.delete();
		host_u.last_idx = -1;
		@(posedge i_clk);
		#10 tx_sof = 1'b1;
		@(posedge i_clk);
		#10 tx_sof = 1'b0;
		foreach (body[i]) begin
			@(posedge i_clk);
			#10 tx_valid = 1'b1;
			tx_data = body[i];
			for (n = 0; n < 20; n++) begin
				@(posedge i_clk);
				if (o_tx_ready === 1'b1) break;
			end
			#10 tx_valid = 1'b0;
			tx_data = ~tx_data;
		end
		tx_eof = 1'b1;
		@(posedge i_clk);
		#10 tx_eof = 1'b0;
		repeat (16) @(posedge i_clk);
		n = body.size();
		check(16'(host_u.got_q.size()), 16'(n + 2));
		foreach (body[i]) check({8'h0, host_u.got_q[i]}, {8'h0, body[i]});
		check({host_u.got_q[n + 1], host_u.got_q[n]}, exp);
		check(16'(host_u.last_idx), 16'(n + 1));
	endtask

	// Clock, cycle ceiling and verdict capture.
	always #50 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (o_rx_done === 1'b1) begin
			done_seen = 1'b1;
			ok_seen = o_rx_crc_ok;
			err_seen = o_rx_crc_err;
		end
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end

	// Main sequence.
	initial begin
		{i_clk, rep_start, bad_f, bad_a, bad_v, tx_sof, tx_valid, tx_eof} = '0;
		{rep_func, tx_data, errors, cmp_count, cycles} = '0;
		{done_seen, ok_seen, err_seen} = '0;
		i_sys_rst = 1'b1;
		repeat (16) @(posedge i_clk);
		#10 i_sys_rst = 1'b0;
		repeat (2) @(posedge i_clk);
		check(host_u.crc16('{8'h01, 8'h03, 8'he0, 8'h03, 8'h00, 8'h02}),
			16'hcb03);
		rx_case('{8'h01, 8'h03, 8'he0, 8'h03, 8'h00, 8'h02}, 1'b0);
		rx_case('{8'h01, 8'h03, 8'he0, 8'h03, 8'h00, 8'h02}, 1'b1);
		rep_case(8'h03, 3'b010, 1'b1, 8'h83, rtu_crc_pkg::CAUSE_CHECK);
		rx_case('{8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00,
			8'h64, 8'h01, 8'h90}, 1'b0);
		rep_case(8'h03, 3'b100, 1'b1, 8'h83, rtu_crc_pkg::CAUSE_FUNC);
		rep_case(8'h10, 3'b010, 1'b1, 8'h90, rtu_crc_pkg::CAUSE_ADDR);
		rep_case(8'h10, 3'b001, 1'b1, 8'h90, rtu_crc_pkg::CAUSE_VALUE);
		rep_case(8'h03, 3'b111, 1'b1, 8'h83, rtu_crc_pkg::CAUSE_FUNC);
		rep_case(8'h03, 3'b000, 1'b0, 8'h03, rtu_crc_pkg::CAUSE_NONE);
		tx_case('{8'h01, 8'h03, 8'h04, 8'h3a, 8'h9a, 8'h00, 8'h05},
			16'hc716);
		tx_case('{8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h02}, 16'h3440);
		wrap_up();
	end
endmodule // testbench
